//--- src/ocs_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Bits 15:14 of the control register always read as zero.
// - With the enable bit clear the output pair is held at a fixed level.
// - With the enable bit set (its default) the divided clock toggles on the pair.
// - The power-down bit (default zero) turns the output pair off.
// - Bits 11:8 are plain storage that resets to all ones.
// - The divide field in bits 7:4 divides the selected source before the pair.
// - Divide codes 0000, 0100, 1000, 1001, 1010 give ratios 1, 2, 4, 8, 16.
// - Divide codes 1100 to 1111 give 5, 10, 20, 25; the other codes are reserved.
// - The select field in bits 3:0, reset zero, chooses the source clock.
// - Codes 00x0 pick the fast recovered byte clock and 00x1 the fast transmit one.
// - Codes 010x pick the fast receiver oscillator divided by four.
// - 0110 picks the slow recovered byte clock, 0111 the slow transmit one; 1xxx reserved.
// - The control register resets to 2f80 hex.
module ocs_top
    import ocs_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port
    input  wire ocs_pkg::ocs_bus_req_t bus_req,
    output logic [ocs_pkg::DATA_W-1:0] rd_data_ff,
    // Clock sources, sampled levels
    input  wire ocs_pkg::ocs_src_t    src_in,
    // Clock output pair
    output logic                      clock_output_pair_p_ff,
    output logic                      clock_output_pair_n_ff,
    output logic                      clock_output_pair_pd_ff
);
    import ocs_pkg::*;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    function automatic logic [RATIO_W-1:0] ocs_ratio(input logic [3:0] code);
        logic [RATIO_W-1:0] r;
        r = RATIO_NONE;
        case (code)
            DIV_CODE_1:  r = RATIO_1;
            DIV_CODE_2:  r = RATIO_2;
            DIV_CODE_4:  r = RATIO_4;
            DIV_CODE_8:  r = RATIO_8;
            DIV_CODE_16: r = RATIO_16;
            DIV_CODE_5:  r = RATIO_5;
            DIV_CODE_10: r = RATIO_10;
            DIV_CODE_20: r = RATIO_20;
            DIV_CODE_25: r = RATIO_25;
            default:     r = RATIO_NONE;
        endcase
        return r;
    endfunction : ocs_ratio

    function automatic logic [SRC_W-1:0] ocs_src_idx(input logic [3:0] code);
        logic [SRC_W-1:0] s;
        s = SRC_NONE;
        if (code[3]) begin
            s = SRC_NONE;
        end else if (code[2:1] == 2'h2) begin
            s = SRC_VCO_DIV4;
        end else if (code[2] == 1'b0) begin
            s = code[0] ? SRC_HS_TX : SRC_HS_RX;
        end else begin
            s = code[0] ? SRC_LS_TX : SRC_LS_RX;
        end
        return s;
    endfunction : ocs_src_idx

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_ff;
    logic              hit_wr;
    logic              hit_rd;

    always_comb begin
        hit_wr = bus_req.wr & (bus_req.addr == CTRL_ADDR);
        hit_rd = bus_req.rd & (bus_req.addr == CTRL_ADDR);
    end

    // Top two bits never stored, so they cannot leak into a read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
        end else if (hit_wr) begin
            ctrl_ff <= bus_req.wdata & CTRL_RD_MASK;
        end
    end

    // Read data stands for exactly one cycle; unmapped reads give zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= RD_ZERO;
        end else if (hit_rd) begin
            rd_data_ff <= ctrl_ff & CTRL_RD_MASK;
        end else begin
            rd_data_ff <= RD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Applied setting
    // ------------------------------------------------------------
    logic [3:0]         sel_field;
    logic [3:0]         div_field;
    logic [SRC_W-1:0]   act_src_ff;
    logic [RATIO_W-1:0] act_ratio_ff;
    logic [SRC_W-1:0]   nxt_src;
    logic [RATIO_W-1:0] nxt_ratio;
    logic               act_hold;
    logic               div_bound;
    logic               load;
    logic               pending;

    always_comb begin
        sel_field = ctrl_ff[SEL_LSB +: FIELD_W];
        div_field = ctrl_ff[DIV_LSB +: FIELD_W];
        nxt_src   = ocs_src_idx(sel_field);
        nxt_ratio = ocs_ratio(div_field);
        act_hold  = (act_src_ff == SRC_NONE) | (act_ratio_ff == RATIO_NONE);
        pending   = (nxt_src != act_src_ff) | (nxt_ratio != act_ratio_ff);
        // Swap only at a period end, or at once when the active source or ratio is reserved
        load      = pending & (div_bound | act_hold);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_src_ff   <= SRC_HS_RX;
            act_ratio_ff <= RATIO_4;
        end else if (load) begin
            act_src_ff   <= nxt_src;
            act_ratio_ff <= nxt_ratio;
        end
    end

    // ------------------------------------------------------------
    // Source mux and divider
    // ------------------------------------------------------------
    logic src_level;
    logic div_out;

    always_comb begin
        case (act_src_ff)
            SRC_HS_RX:    src_level = src_in.hs_rx_byte;
            SRC_HS_TX:    src_level = src_in.hs_tx_byte;
            SRC_VCO_DIV4: src_level = src_in.vco_div4;
            SRC_LS_RX:    src_level = src_in.ls_rx_byte;
            SRC_LS_TX:    src_level = src_in.ls_tx_byte;
            default:      src_level = 1'b0;
        endcase
    end

    ocs_div #(
        .RATIO_W (RATIO_W)
    ) u_div (
        .clk     (clk),
        .rst     (rst),
        .src     (src_level),
        .ratio   (act_ratio_ff),
        .clear   (load),
        .div_out (div_out),
        .bound   (div_bound)
    );

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic en_bit;
    logic pd_bit;
    logic nxt_p;
    logic nxt_n;

    always_comb begin
        en_bit = ctrl_ff[EN_BIT];
        pd_bit = ctrl_ff[PD_BIT];
        if (pd_bit) begin
            nxt_p = 1'b0;
            nxt_n = 1'b0;
        end else if (!en_bit || act_hold) begin
            nxt_p = 1'b0;
            nxt_n = 1'b1;
        end else begin
            nxt_p = div_out;
            nxt_n = ~div_out;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_output_pair_p_ff  <= 1'b0;
            clock_output_pair_n_ff  <= 1'b1;
            clock_output_pair_pd_ff <= 1'b0;
        end else begin
            clock_output_pair_p_ff  <= nxt_p;
            clock_output_pair_n_ff  <= nxt_n;
            clock_output_pair_pd_ff <= pd_bit;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RD_TOP_ZERO: assert property (
        bus_req.rd |=> rd_data_ff[15:14] == 2'h0)
        else $error("Top bits of read data not zero");

    AST_WR_RD_BACK: assert property (
        (hit_wr ##1 hit_rd) |=> rd_data_ff == ($past(bus_req.wdata, 2) & CTRL_RD_MASK))
        else $error("Read back differs from written value");

    AST_DISABLE_HOLD: assert property (
        (!en_bit && !pd_bit) |=> (!clock_output_pair_p_ff && clock_output_pair_n_ff))
        else $error("Pair moved while disabled");

    AST_ENABLE_FOLLOW: assert property (
        (en_bit && !pd_bit && !act_hold) |=> clock_output_pair_p_ff == $past(div_out))
        else $error("Pair does not follow divided clock");

    AST_POWER_DOWN: assert property (
        pd_bit |=> (clock_output_pair_pd_ff && !clock_output_pair_p_ff
                    && !clock_output_pair_n_ff))
        else $error("Pair not off in power down");

    AST_DIV_MAP: assert property (
        (div_field == DIV_CODE_8) |-> nxt_ratio == RATIO_8)
        else $error("Divide code 1001 not ratio 8");

    AST_DIV_MAP_HI: assert property (
        (div_field == DIV_CODE_25) |-> nxt_ratio == RATIO_25)
        else $error("Divide code 1111 not ratio 25");

    AST_SRC_MAP: assert property (
        (sel_field[3:2] == 2'h0) |-> nxt_src == {2'h0, sel_field[0]})
        else $error("Fast byte clock select wrong");

    AST_SRC_VCO: assert property (
        (sel_field[3:1] == 3'h2) |-> nxt_src == SRC_VCO_DIV4)
        else $error("Oscillator select wrong");

    AST_RESET_VALUE: assert property (
        $fell(rst) |-> ctrl_ff == CTRL_RESET)
        else $error("Control register reset value wrong");

    AST_GLITCH_FREE: assert property (
        ($changed(act_src_ff) || $changed(act_ratio_ff))
            |-> $past(div_bound) || $past(act_hold))
        else $error("Setting swapped mid period");

    AST_SWAP_LOW: assert property (
        load |=> !div_out)
        else $error("Divided clock not low after setting swap");

    AST_RD_IDLE: assert property (
        !hit_rd |=> rd_data_ff == RD_ZERO)
        else $error("Read data not zero outside a read");

    AST_WR_STORE: assert property (
        hit_wr |=> ctrl_ff == ($past(bus_req.wdata) & CTRL_RD_MASK))
        else $error("Control register did not store write");

    AST_DIV_MAP_LO: assert property (
        (div_field == DIV_CODE_2) |-> nxt_ratio == RATIO_2)
        else $error("Divide code 0100 not ratio 2");

    AST_DIV_MAP_5: assert property (
        (div_field == DIV_CODE_5) |-> nxt_ratio == RATIO_5)
        else $error("Divide code 1100 not ratio 5");

    AST_SRC_LS: assert property (
        (sel_field[3:1] == 3'h3) |-> nxt_src == (sel_field[0] ? SRC_LS_TX : SRC_LS_RX))
        else $error("Slow byte clock select wrong");

    AST_SRC_RSVD: assert property (
        sel_field[3] |-> nxt_src == SRC_NONE)
        else $error("Reserved select not refused");

    AST_PAIR_COMPL: assert property (
        (en_bit && !pd_bit) |=> clock_output_pair_n_ff == !clock_output_pair_p_ff)
        else $error("Pair sides not complementary");

    AST_PD_FLAG: assert property (
        !pd_bit |=> !clock_output_pair_pd_ff)
        else $error("Power down flag set in normal operation");

    AST_RSVD_HOLD: assert property (
        (act_hold && !pd_bit) [*2] |=> !clock_output_pair_p_ff)
        else $error("Pair toggled on reserved code");

    COV_DIV_CHANGE: cover property (load && !act_hold);
    COV_PD:         cover property ($rose(clock_output_pair_pd_ff));
    COV_TOGGLE:     cover property ($rose(clock_output_pair_p_ff) ##[1:60] $fell(clock_output_pair_p_ff));
    COV_RSVD:       cover property (act_hold && pd_bit == 1'b0 && en_bit);
    COV_LEAVE_RSVD: cover property (load && act_hold);

endmodule : ocs_top
`default_nettype wire

//--- shared/ocs_pkg.sv
package ocs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 16;
    localparam int          RATIO_W       = 5;
    localparam int          SRC_W         = 3;
    localparam logic [7:0]  CTRL_ADDR     = 8'h0d;
    localparam logic [15:0] CTRL_RESET    = 16'h2f80;
    localparam logic [15:0] CTRL_RD_MASK  = 16'h3fff;
    localparam logic [15:0] RD_ZERO       = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          EN_BIT        = 13;
    localparam int          PD_BIT        = 12;
    localparam int          DIV_LSB       = 4;
    localparam int          SEL_LSB       = 0;
    localparam int          FIELD_W       = 4;

    // ------------------------------------------------------------
    // Divide codes and ratios
    // ------------------------------------------------------------
    localparam logic [3:0]  DIV_CODE_1    = 4'h0;
    localparam logic [3:0]  DIV_CODE_2    = 4'h4;
    localparam logic [3:0]  DIV_CODE_4    = 4'h8;
    localparam logic [3:0]  DIV_CODE_8    = 4'h9;
    localparam logic [3:0]  DIV_CODE_16   = 4'ha;
    localparam logic [3:0]  DIV_CODE_5    = 4'hc;
    localparam logic [3:0]  DIV_CODE_10   = 4'hd;
    localparam logic [3:0]  DIV_CODE_20   = 4'he;
    localparam logic [3:0]  DIV_CODE_25   = 4'hf;
    localparam logic [4:0]  RATIO_NONE    = 5'h00;
    localparam logic [4:0]  RATIO_1       = 5'h01;
    localparam logic [4:0]  RATIO_2       = 5'h02;
    localparam logic [4:0]  RATIO_4       = 5'h04;
    localparam logic [4:0]  RATIO_5       = 5'h05;
    localparam logic [4:0]  RATIO_8       = 5'h08;
    localparam logic [4:0]  RATIO_10      = 5'h0a;
    localparam logic [4:0]  RATIO_16      = 5'h10;
    localparam logic [4:0]  RATIO_20      = 5'h14;
    localparam logic [4:0]  RATIO_25      = 5'h19;

    // ------------------------------------------------------------
    // Source indices
    // ------------------------------------------------------------
    localparam logic [2:0]  SRC_HS_RX     = 3'h0;
    localparam logic [2:0]  SRC_HS_TX     = 3'h1;
    localparam logic [2:0]  SRC_VCO_DIV4  = 3'h2;
    localparam logic [2:0]  SRC_LS_RX     = 3'h3;
    localparam logic [2:0]  SRC_LS_TX     = 3'h4;
    localparam logic [2:0]  SRC_NONE      = 3'h7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ocs_bus_req_t;

    typedef struct packed {
        logic hs_rx_byte;
        logic hs_tx_byte;
        logic vco_div4;
        logic ls_rx_byte;
        logic ls_tx_byte;
    } ocs_src_t;

endpackage : ocs_pkg

//--- src/ocs_div.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_div #(
    parameter int RATIO_W = 5
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Source and setting
    input  wire logic               src,
    input  wire logic [RATIO_W-1:0] ratio,
    input  wire logic               clear,
    // Divided clock and period-end strobe
    output logic                    div_out,
    output logic                    bound
);
    logic               src_q_ff;
    logic [RATIO_W-1:0] cnt_ff;
    logic               out_ff;
    logic               wrap_ff;
    logic               rise;
    logic [RATIO_W:0]   half;
    logic [RATIO_W-1:0] nxt_cnt;
    logic [RATIO_W-1:0] last;

    always_comb begin
        rise    = src & ~src_q_ff;
        half    = ({1'b0, ratio} + {{RATIO_W{1'b0}}, 1'b1}) >> 1;
        last    = ratio - {{(RATIO_W-1){1'b0}}, 1'b1};
        // Pending restart: next source edge opens a full period, so no short pulse
        nxt_cnt = (wrap_ff || (cnt_ff >= last)) ? '0 : cnt_ff + {{(RATIO_W-1){1'b0}}, 1'b1};
        bound   = rise & (wrap_ff | (cnt_ff >= last));
        div_out = (ratio == {{(RATIO_W-1){1'b0}}, 1'b1}) ? (src_q_ff & ~wrap_ff) : out_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q_ff <= 1'b0;
        end else begin
            src_q_ff <= src;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= '0;
            out_ff  <= 1'b0;
            wrap_ff <= 1'b1;
        end else if (clear) begin
            // Low until the new source edge; stretches low, never cuts high
            cnt_ff  <= '0;
            out_ff  <= 1'b0;
            wrap_ff <= 1'b1;
        end else if (rise) begin
            cnt_ff  <= nxt_cnt;
            out_ff  <= ({1'b0, nxt_cnt} < half);
            wrap_ff <= 1'b0;
        end
    end

endmodule : ocs_div
`default_nettype wire

//--- tb/ocs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_board_model (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Sources toward the block
    output ocs_pkg::ocs_src_t src_out,
    // Output clock as the board sees it
    input  wire logic         pair_p,
    output logic [15:0]       period_ff,
    output logic [15:0]       rises_ff
);
    import ocs_pkg::*;

    logic [31:0] tick_ff;
    logic [15:0] cyc_ff;
    logic        prev_ff;

    function automatic logic lvl(input logic [31:0] t, input logic [31:0] h);
        return ((t / h) % 32'h2) != 32'h0;
    endfunction : lvl

    // ------------------------------------------------------------
    // Sources
    // ------------------------------------------------------------
    // Half periods 2..6 clk, all slower than clk/2 so the block can sample them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_ff <= '0;
            src_out <= '0;
        end else begin
            tick_ff <= tick_ff + 32'h1;
            src_out <= {lvl(tick_ff, 32'h2), lvl(tick_ff, 32'h3), lvl(tick_ff, 32'h4),
                        lvl(tick_ff, 32'h5), lvl(tick_ff, 32'h6)};
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    // Rising edge to rising edge, in clk cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ff   <= 1'b0;
            cyc_ff    <= 16'h0;
            period_ff <= 16'h0;
            rises_ff  <= 16'h0;
        end else begin
            prev_ff <= pair_p;
            if (pair_p && !prev_ff) begin
                period_ff <= cyc_ff;
                cyc_ff    <= 16'h1;
                rises_ff  <= rises_ff + 16'h1;
            end else begin
                cyc_ff <= cyc_ff + 16'h1;
            end
        end
    end
endmodule : ocs_board_model
`default_nettype wire

//--- tb/tb_output_clock_select_divide.sv
`timescale 1ns/1ps
`default_nettype none
module tb_output_clock_select_divide;
    import ocs_pkg::*;

    logic         clk = 1'b0;
    logic         rst;
    ocs_bus_req_t bus_req;
    logic [15:0]  rd_data;
    ocs_src_t     src;
    logic         p;
    logic         n;
    logic         pd;
    logic [15:0]  period;
    logic [15:0]  rises;
    int           bad_count = 0;
    int           n_checks = 0;
    int           cycles = 0;
    logic [3:0]   divc [9] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he, 4'hf};
    int           ratio [9] = '{1, 2, 4, 8, 16, 5, 10, 20, 25};
    int           half [8] = '{2, 3, 2, 3, 4, 4, 5, 6};

    always #50 clk = ~clk;

    ocs_top dut_u (
        .clk                     (clk),
        .rst                     (rst),
        .bus_req                 (bus_req),
        .rd_data_ff              (rd_data),
        .src_in                  (src),
        .clock_output_pair_p_ff  (p),
        .clock_output_pair_n_ff  (n),
        .clock_output_pair_pd_ff (pd)
    );

    ocs_board_model board_u (
        .clk       (clk),
        .rst       (rst),
        .src_out   (src),
        .pair_p    (p),
        .period_ff (period),
        .rises_ff  (rises)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Generous ceiling: the longest setting needs about 300 cycles per check
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req.wr    <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // Write then read with no gap between the strobes
    task automatic wrrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp,
                        input string what);
        @(posedge clk);
        bus_req.wr    <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(what, exp, rd_data);
    endtask : wrrd

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        bus_req.rd   <= 1'b1;
        bus_req.addr <= a;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(what, exp, rd_data);
    endtask : rdchk

    task automatic wait_rise;
        int          i;
        logic [15:0] r0;
        r0 = rises;
        i = 0;
        while (rises === r0 && i < 400) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i >= 400) begin
            chk("output rise", 16'h1, 16'h0);
        end
    endtask : wait_rise

    // Period between the second and third rise, so a pending setting has surely been applied
    task automatic meas(input int exp, input string what);
        repeat (3) wait_rise();
        chk(what, 16'(exp), period);
        chk("complement", {15'h0, ~p}, {15'h0, n});
    endtask : meas

    task automatic held(input logic [2:0] e, input string what);
        repeat (120) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            #1;
            chk(what, {13'h0, e}, {13'h0, p, n, pd});
        end
    endtask : held

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        bus_req = '0;
        repeat (8) @(posedge clk);
        #1;
        chk("pins in reset", 16'h2, {13'h0, p, n, pd});
        @(posedge clk);
        rst <= 1'b0;
        rdchk(CTRL_ADDR, 16'h2f80, "reset value");
        @(posedge clk);
        #1;
        chk("read idle", 16'h0, rd_data);
        meas(16, "default output");
        wrrd(CTRL_ADDR, 16'hffff, 16'h3fff, "top bits");
        wr(8'h0e, 16'h0000);
        rdchk(8'h0e, 16'h0000, "unmapped");
        rdchk(CTRL_ADDR, 16'h3fff, "storage kept");
        wrrd(CTRL_ADDR, 16'h2080, 16'h2080, "reserved bits");
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            wr(CTRL_ADDR, {8'h2f, divc[i], 4'h0});
            meas(4 * ratio[i], "divide");
        end
        $display("test divide done");
        for (int s = 0; s < 8; s++) begin
            wr(CTRL_ADDR, {12'h2f0, 4'(s)});
            meas(2 * half[s], "select");
        end
        $display("test select done");
        wr(CTRL_ADDR, 16'h2f10);
        held(3'b010, "reserved divide");
        wr(CTRL_ADDR, 16'h2f08);
        held(3'b010, "reserved select");
        wr(CTRL_ADDR, 16'h2f80);
        meas(16, "after reserved");
        $display("test reserved done");
        wr(CTRL_ADDR, 16'h0f80);
        held(3'b010, "disabled");
        wr(CTRL_ADDR, 16'h3f80);
        held(3'b001, "power down");
        wr(CTRL_ADDR, 16'h2f80);
        meas(16, "re-enabled");
        $display("test enable done");
        final_report();
    end
endmodule : tb_output_clock_select_divide
`default_nettype wire
